// ### rtl/tec_ctrl_pkg.sv
// Functional notes
// - Upper clamp field caps effective voltage code
// - Lower clamp field floors effective voltage code
// - Skip cycles when limited at min time
// - I/O supply or thermal fault forces internal reset
// - Software reset bit triggers same reset
// - Reset restores registers except status register
// - Latched faults keep both drivers disabled
// - Status shows four live, unlatched indications
// - Six fault flags stick until cleared
// - Reset sets sticky reset-occurred flag
// - Select field routes signal to monitor pin
// - Test bit rescales monitor codes 5-11 except 9
// - Switching needs pin high and request bit
// - Pin driven low on detected fault
// - External low on pin idles switch node
// - Pin released once status 10:4 clear
// - Voltage code sign-extends from bit 25
// - Linear stage needs enable bit and no faults
package tec_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus geometry and register indices (byte address = 4 * index)
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [2:0] IDX_COMMAND = 3'h0;
  localparam logic [2:0] IDX_STATUS = 3'h1;
  localparam logic [2:0] IDX_NEG_LIMIT = 3'h2;
  localparam logic [2:0] IDX_POS_LIMIT = 3'h3;
  localparam logic [2:0] IDX_VOLTAGE = 3'h4;
  localparam logic [2:0] IDX_UPPER_CLAMP = 3'h5;
  localparam logic [2:0] IDX_LOWER_CLAMP = 3'h6;
  localparam logic [2:0] IDX_MONITOR = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  localparam int unsigned CMD_W = 22;
  localparam logic [21:0] CMD_RST = 22'h08_a214;
  localparam int unsigned CMD_ENABLE_BIT = 0;
  localparam int unsigned CMD_SWITCH_ENABLE_REQUEST_BIT = 1;
  localparam int unsigned CMD_SOFT_RST_BIT = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Status register layout
  localparam int unsigned STAT_W = 11;
  localparam int unsigned ST_SWITCHING = 0;
  localparam int unsigned ST_CUR_LIMIT = 1;
  localparam int unsigned ST_PWR_LIMIT = 2;
  localparam int unsigned ST_MIN_TIME = 3;
  localparam int unsigned ST_RESET_OCC = 4;
  localparam int unsigned ST_FAULT_LSB = 5;
  localparam int unsigned NUM_FAULTS = 6;
  localparam logic [10:0] STAT_RST = 11'h010;

  ////////////////////////////////////////////////////////////////////////////
  // Limit, voltage and clamp registers
  localparam int unsigned LIM_W = 9;
  localparam logic [8:0] NEG_LIMIT_RST = 9'h1ff;
  localparam logic [8:0] POS_LIMIT_RST = 9'h000;
  localparam int unsigned VCODE_W = 26;
  localparam logic [25:0] VOLTAGE_RST = 26'h300_0000;
  localparam logic [3:0] UPPER_CLAMP_RST = 4'hf;
  localparam logic [3:0] LOWER_CLAMP_RST = 4'h0;
  localparam logic [7:0] UPPER_TOP = 8'h00;
  localparam logic [19:0] UPPER_FILL = 20'hf_ffff;
  localparam logic [7:0] LOWER_TOP = 8'hff;
  localparam logic [19:0] LOWER_FILL = 20'h0_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Monitor select register
  localparam int unsigned MUX_W = 7;
  localparam logic [6:0] MUX_RST = 7'h00;
  localparam int unsigned MUX_OE_BIT = 4;
  localparam int unsigned MUX_TEST_BIT = 5;
  localparam logic [3:0] MON_SCALE_FIRST = 4'h5;
  localparam logic [3:0] MON_SCALE_LAST = 4'hb;
  localparam logic [3:0] MON_SCALE_SKIP = 4'h9;
  localparam logic [3:0] MON_SWITCH_FB = 4'hc;

endpackage

// ### rtl/voltage_clamp.sv
`timescale 1ns/1ps
module voltage_clamp (
  // Stored code and clamp fields
  input wire logic [25:0] code_i,
  input wire logic [3:0] upper_voltage_clamp_i,
  input wire logic [3:0] lower_voltage_clamp_i,
  // Saturated code
  output logic [31:0] effective_code_o
);

  logic signed [31:0] code_ext;
  logic signed [31:0] upper_bound;
  logic signed [31:0] lower_bound;

  // Sign extension and window bounds
  assign code_ext = {{6{code_i[25]}}, code_i};
  assign upper_bound = {tec_ctrl_pkg::UPPER_TOP, upper_voltage_clamp_i,
                        tec_ctrl_pkg::UPPER_FILL};
  assign lower_bound = {tec_ctrl_pkg::LOWER_TOP, lower_voltage_clamp_i,
                        tec_ctrl_pkg::LOWER_FILL};

  // Saturate to the nearest bound
  always_comb begin
    if (code_ext > upper_bound) begin
      effective_code_o = upper_bound;
    end else if (code_ext < lower_bound) begin
      effective_code_o = lower_bound;
    end else begin
      effective_code_o = code_ext;
    end
  end

endmodule

// ### rtl/monitor_route.sv
`timescale 1ns/1ps
module monitor_route (
  // Select field and test bit
  input wire logic [3:0] monitor_channel_select_i,
  input wire logic monitor_test_bit_i,
  // Routed channel and scaling change
  output logic [3:0] route_o,
  output logic scale_alt_o
);

  // Top four codes all pick the switch-side feedback
  always_comb begin
    if (monitor_channel_select_i >= tec_ctrl_pkg::MON_SWITCH_FB) begin
      route_o = tec_ctrl_pkg::MON_SWITCH_FB;
    end else begin
      route_o = monitor_channel_select_i;
    end
  end

  // Scaling change only on the documented subset
  assign scale_alt_o = monitor_test_bit_i &&
    (monitor_channel_select_i >= tec_ctrl_pkg::MON_SCALE_FIRST) &&
    (monitor_channel_select_i <= tec_ctrl_pkg::MON_SCALE_LAST) &&
    (monitor_channel_select_i != tec_ctrl_pkg::MON_SCALE_SKIP);

endmodule

// ### rtl/tec_driver_protect_ctrl.sv
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module tec_driver_protect_ctrl (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Live analog indications
  input wire logic current_limit_active_i,
  input wire logic power_limit_active_i,
  input wire logic min_time_limited_i,
  // Fault events from the analog side
  input wire logic linear_overcurrent_i,
  input wire logic overtemp_i,
  input wire logic core_supply_low_i,
  input wire logic io_supply_low_i,
  input wire logic charge_pump_low_i,
  input wire logic reference_low_i,
  input wire logic fault_i,
  // Switch-enable pin
  input wire logic switch_enable_pin_i,
  output logic switch_enable_pin_o,
  output logic switch_enable_pin_oe_n_o,
  // Power stage control
  output logic internal_switch_enable_o,
  output logic switch_node_hiz_o,
  output logic linear_enable_o,
  output logic skip_cycle_o,
  output logic [31:0] effective_voltage_code_o,
  output logic [8:0] positive_current_limit_code_o,
  output logic [8:0] negative_current_limit_code_o,
  // Monitor pin control
  output logic [3:0] monitor_channel_o,
  output logic monitor_output_enable_o,
  output logic monitor_scale_alt_o,
  // Soft reset indication
  output logic soft_reset_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [21:0] cmd;
    logic [10:0] stat;
    logic [8:0] neg_limit;
    logic [8:0] pos_limit;
    logic [25:0] vcode;
    logic [3:0] upper_clamp;
    logic [3:0] lower_clamp;
    logic [6:0] mux;
    logic [31:0] rdata;
    logic pin_oe_n;
    logic sw_en;
    logic hiz;
    logic lin_en;
    logic skip;
    logic [31:0] eff_code;
    logic [3:0] mon_chan;
    logic mon_oe;
    logic mon_scale;
    logic soft_rst;
  } state_s;

  localparam state_s STATE_RST = '{
    cmd: tec_ctrl_pkg::CMD_RST,
    stat: tec_ctrl_pkg::STAT_RST,
    neg_limit: tec_ctrl_pkg::NEG_LIMIT_RST,
    pos_limit: tec_ctrl_pkg::POS_LIMIT_RST,
    vcode: tec_ctrl_pkg::VOLTAGE_RST,
    upper_clamp: tec_ctrl_pkg::UPPER_CLAMP_RST,
    lower_clamp: tec_ctrl_pkg::LOWER_CLAMP_RST,
    mux: tec_ctrl_pkg::MUX_RST,
    rdata: 32'h0000_0000,
    pin_oe_n: 1'b0,
    sw_en: 1'b0,
    hiz: 1'b1,
    lin_en: 1'b0,
    skip: 1'b0,
    eff_code: 32'hff00_0000,
    mon_chan: 4'h0,
    mon_oe: 1'b0,
    mon_scale: 1'b0,
    soft_rst: 1'b0
  };

  state_s state_ff;
  state_s nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // Helper nets

  logic [2:0] reg_idx;
  logic addr_hit;
  logic [31:0] clamped_code;
  logic [3:0] mon_route;
  logic mon_scale_alt;
  logic [5:0] fault_events;
  logic [5:0] fault_flags;
  logic any_fault;
  logic soft_rst_req;
  logic wr_cmd;
  logic wr_stat;
  logic pin_pull_low;
  logic sw_en_now;
  logic [10:0] stat_view;

  // Word-aligned decode of the eight registers
  assign reg_idx = addr_i[4:2];
  assign addr_hit = (addr_i[1:0] == 2'b00) && (addr_i[7:5] == 3'b000);
  assign wr_cmd = wr_i && addr_hit && (reg_idx == tec_ctrl_pkg::IDX_COMMAND);
  assign wr_stat = wr_i && addr_hit && (reg_idx == tec_ctrl_pkg::IDX_STATUS);

  // Fault events in status bit order
  assign fault_events = {reference_low_i, charge_pump_low_i,
                         io_supply_low_i, core_supply_low_i,
                         overtemp_i, linear_overcurrent_i};
  assign fault_flags = state_ff.stat[10:5];
  assign any_fault = |fault_flags;

  // Internal reset from I/O supply or thermal fault, or from software
  assign soft_rst_req = io_supply_low_i || overtemp_i
    || (wr_cmd && wdata_i[tec_ctrl_pkg::CMD_SOFT_RST_BIT]);

  // Pin is pulled low on a fault or while any status bit 10:4 is set
  assign pin_pull_low = fault_i || (|state_ff.stat[10:4]);

  // Switching needs the pin, the request bit and a clean fault record
  assign sw_en_now = switch_enable_pin_i
    && state_ff.cmd[tec_ctrl_pkg::CMD_SWITCH_ENABLE_REQUEST_BIT]
    && !any_fault && !pin_pull_low;

  // Status as read: live bits merged over the latched ones
  always_comb begin
    stat_view = state_ff.stat;
    stat_view[tec_ctrl_pkg::ST_SWITCHING] = state_ff.sw_en;
    stat_view[tec_ctrl_pkg::ST_CUR_LIMIT] = current_limit_active_i;
    stat_view[tec_ctrl_pkg::ST_PWR_LIMIT] = power_limit_active_i;
    stat_view[tec_ctrl_pkg::ST_MIN_TIME] = min_time_limited_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath helpers

  voltage_clamp u_clamp (
    .code_i(state_ff.vcode),
    .upper_voltage_clamp_i(state_ff.upper_clamp),
    .lower_voltage_clamp_i(state_ff.lower_clamp),
    .effective_code_o(clamped_code)
  );

  monitor_route u_monitor (
    .monitor_channel_select_i(state_ff.mux[3:0]),
    .monitor_test_bit_i(state_ff.mux[tec_ctrl_pkg::MUX_TEST_BIT]),
    .route_o(mon_route),
    .scale_alt_o(mon_scale_alt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    nxt_state = state_ff;

    // Register writes
    if (wr_i && addr_hit) begin
      case (reg_idx)
        tec_ctrl_pkg::IDX_COMMAND: begin
          nxt_state.cmd = wdata_i[21:0];
          nxt_state.cmd[tec_ctrl_pkg::CMD_SOFT_RST_BIT] = 1'b0;
        end
        tec_ctrl_pkg::IDX_NEG_LIMIT: begin
          nxt_state.neg_limit = wdata_i[8:0];
        end
        tec_ctrl_pkg::IDX_POS_LIMIT: begin
          nxt_state.pos_limit = wdata_i[8:0];
        end
        tec_ctrl_pkg::IDX_VOLTAGE: begin
          nxt_state.vcode = wdata_i[25:0];
        end
        tec_ctrl_pkg::IDX_UPPER_CLAMP: begin
          nxt_state.upper_clamp = wdata_i[3:0];
        end
        tec_ctrl_pkg::IDX_LOWER_CLAMP: begin
          nxt_state.lower_clamp = wdata_i[3:0];
        end
        tec_ctrl_pkg::IDX_MONITOR: begin
          nxt_state.mux = wdata_i[6:0];
        end
        default: begin
          nxt_state.mux = state_ff.mux;
        end
      endcase
    end

    // Latched status bits: writing zero clears, a new event wins
    if (wr_stat) begin
      nxt_state.stat[10:4] = state_ff.stat[10:4] & wdata_i[10:4];
    end
    nxt_state.stat[3:0] = 4'h0;
    nxt_state.stat[10:5] = nxt_state.stat[10:5] | fault_events;

    // Internal reset restores all but the status register
    if (soft_rst_req) begin
      nxt_state.cmd = tec_ctrl_pkg::CMD_RST;
      nxt_state.neg_limit = tec_ctrl_pkg::NEG_LIMIT_RST;
      nxt_state.pos_limit = tec_ctrl_pkg::POS_LIMIT_RST;
      nxt_state.vcode = tec_ctrl_pkg::VOLTAGE_RST;
      nxt_state.upper_clamp = tec_ctrl_pkg::UPPER_CLAMP_RST;
      nxt_state.lower_clamp = tec_ctrl_pkg::LOWER_CLAMP_RST;
      nxt_state.mux = tec_ctrl_pkg::MUX_RST;
      nxt_state.stat[tec_ctrl_pkg::ST_RESET_OCC] = 1'b1;
    end
    nxt_state.soft_rst = soft_rst_req;

    // Read data, valid only in the cycle after the strobe
    nxt_state.rdata = 32'h0000_0000;
    if (rd_i && addr_hit) begin
      case (reg_idx)
        tec_ctrl_pkg::IDX_COMMAND: begin
          nxt_state.rdata = {10'h000, state_ff.cmd};
        end
        tec_ctrl_pkg::IDX_STATUS: begin
          nxt_state.rdata = {21'h00_0000, stat_view};
        end
        tec_ctrl_pkg::IDX_NEG_LIMIT: begin
          nxt_state.rdata = {23'h00_0000, state_ff.neg_limit};
        end
        tec_ctrl_pkg::IDX_POS_LIMIT: begin
          nxt_state.rdata = {23'h00_0000, state_ff.pos_limit};
        end
        tec_ctrl_pkg::IDX_VOLTAGE: begin
          nxt_state.rdata = {{6{state_ff.vcode[25]}}, state_ff.vcode};
        end
        tec_ctrl_pkg::IDX_UPPER_CLAMP: begin
          nxt_state.rdata = {28'h000_0000, state_ff.upper_clamp};
        end
        tec_ctrl_pkg::IDX_LOWER_CLAMP: begin
          nxt_state.rdata = {28'h000_0000, state_ff.lower_clamp};
        end
        tec_ctrl_pkg::IDX_MONITOR: begin
          nxt_state.rdata = {25'h000_0000, state_ff.mux};
        end
        default: begin
          nxt_state.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Pin drive and switching stage
    nxt_state.pin_oe_n = !pin_pull_low;
    nxt_state.sw_en = sw_en_now;
    nxt_state.hiz = !sw_en_now;

    // Linear stage needs the enable bit and no latched fault
    nxt_state.lin_en = state_ff.cmd[tec_ctrl_pkg::CMD_ENABLE_BIT]
      && !any_fault;

    // Pulse skipping while current-limited at minimum on/off time
    nxt_state.skip = sw_en_now && current_limit_active_i
      && min_time_limited_i;

    // Clamped code and monitor routing
    nxt_state.eff_code = clamped_code;
    nxt_state.mon_chan = mon_route;
    nxt_state.mon_oe = state_ff.mux[tec_ctrl_pkg::MUX_OE_BIT];
    nxt_state.mon_scale = mon_scale_alt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register except the constant-low pin drive

  assign rdata_o = state_ff.rdata;
  assign switch_enable_pin_o = 1'b0;
  assign switch_enable_pin_oe_n_o = state_ff.pin_oe_n;
  assign internal_switch_enable_o = state_ff.sw_en;
  assign switch_node_hiz_o = state_ff.hiz;
  assign linear_enable_o = state_ff.lin_en;
  assign skip_cycle_o = state_ff.skip;
  assign effective_voltage_code_o = state_ff.eff_code;
  assign positive_current_limit_code_o = state_ff.pos_limit;
  assign negative_current_limit_code_o = state_ff.neg_limit;
  assign monitor_channel_o = state_ff.mon_chan;
  assign monitor_output_enable_o = state_ff.mon_oe;
  assign monitor_scale_alt_o = state_ff.mon_scale;
  assign soft_reset_o = state_ff.soft_rst;

endmodule

// ### dv/tec_driver_protect_ctrl_properties.sv
`timescale 1ns/1ps
module tec_driver_protect_ctrl_checker (
  // Clock, reset and bus
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  // Analog side and pin
  input wire logic current_limit_active_i,
  input wire logic min_time_limited_i,
  input wire logic linear_overcurrent_i,
  input wire logic overtemp_i,
  input wire logic io_supply_low_i,
  input wire logic fault_i,
  input wire logic switch_enable_pin_i,
  // Watched outputs
  input wire logic switch_enable_pin_oe_n_o,
  input wire logic internal_switch_enable_o,
  input wire logic switch_node_hiz_o,
  input wire logic linear_enable_o,
  input wire logic skip_cycle_o,
  input wire logic [31:0] effective_voltage_code_o,
  input wire logic [3:0] monitor_channel_o,
  input wire logic monitor_scale_alt_o,
  input wire logic soft_reset_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  // Pin and switching relations
  pin_low_stop_a: assert property (
    !switch_enable_pin_i |=> !internal_switch_enable_o)
    else $error("switching without pin high");
  hiz_tracks_a: assert property (
    switch_node_hiz_o == !internal_switch_enable_o)
    else $error("switch node state wrong");
  fault_pin_low_a: assert property (
    fault_i |=> !switch_enable_pin_oe_n_o)
    else $error("pin not pulled low on fault");
  skip_cause_a: assert property (
    skip_cycle_o |-> $past(current_limit_active_i && min_time_limited_i))
    else $error("skip without limit and min time");
  drivers_off_a: assert property (
    linear_overcurrent_i |->
      ##2 (!linear_enable_o && !internal_switch_enable_o))
    else $error("driver on with latched fault");

  // Reset requests
  fault_reset_a: assert property (
    (io_supply_low_i || overtemp_i) |=> soft_reset_o)
    else $error("no reset on supply or thermal fault");
  soft_reset_a: assert property (
    wr_i && addr_i == 8'h00 && wdata_i[20] |=> soft_reset_o)
    else $error("no reset on software request");

  // Code window and monitor routing
  code_window_a: assert property (
    $signed(effective_voltage_code_o) <= 32'sh00ff_ffff &&
    $signed(effective_voltage_code_o) >= 32'shff00_0000)
    else $error("effective code outside window");
  mon_route_a: assert property (
    monitor_channel_o <= 4'hc)
    else $error("monitor channel out of range");
  mon_scale_a: assert property (
    monitor_scale_alt_o |-> monitor_channel_o inside {[4'h5:4'hb]} &&
      monitor_channel_o != 4'h9)
    else $error("scaling on wrong channel");
endmodule

bind tec_driver_protect_ctrl tec_driver_protect_ctrl_checker u_chk (
  .clock_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .current_limit_active_i,
  .min_time_limited_i, .linear_overcurrent_i, .overtemp_i, .io_supply_low_i,
  .fault_i, .switch_enable_pin_i, .switch_enable_pin_oe_n_o,
  .internal_switch_enable_o, .switch_node_hiz_o, .linear_enable_o,
  .skip_cycle_o, .effective_voltage_code_o, .monitor_channel_o,
  .monitor_scale_alt_o, .soft_reset_o);

// ### dv/sw_pin_model.sv
`timescale 1ns/1ps
module sw_pin_model (
  // Device drive and outside pull-down
  input wire logic drv_i,
  input wire logic oe_n_i,
  input wire logic ext_low_i,
  // Resolved pin level
  output logic level_o
);
  // Pull-up holds the pin high unless someone sinks it
  assign level_o = ((!oe_n_i && !drv_i) || ext_low_i) ? 1'b0 : 1'b1;
endmodule

// ### dv/tec_driver_protect_ctrl_bench.sv
`timescale 1ns/1ps
module tec_driver_protect_ctrl_bench;
  // Stimulus, observed outputs and bookkeeping
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic cl = 1'b0, pl = 1'b0, mt = 1'b0, fault = 1'b0, ext_low = 1'b0;
  logic [5:0] flt = 6'h00;
  logic [31:0] rdata, eff, seed = 32'h0000_9f7c;
  logic pin, pin_o, oe_n, sw_en, hiz, lin_en, skip, oe_m, alt, srst;
  logic [8:0] plim, nlim;
  logic [3:0] chan;
  logic [31:0] exp_q[$];
  int fail_count = 0;
  int num_checks = 0;

  always #50 clock_i = ~clock_i;

  tec_driver_protect_ctrl DUT (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .current_limit_active_i(cl), .power_limit_active_i(pl),
    .min_time_limited_i(mt), .linear_overcurrent_i(flt[0]),
    .overtemp_i(flt[1]), .core_supply_low_i(flt[2]),
    .io_supply_low_i(flt[3]), .charge_pump_low_i(flt[4]),
    .reference_low_i(flt[5]), .fault_i(fault), .switch_enable_pin_i(pin),
    .switch_enable_pin_o(pin_o), .switch_enable_pin_oe_n_o(oe_n),
    .internal_switch_enable_o(sw_en), .switch_node_hiz_o(hiz),
    .linear_enable_o(lin_en), .skip_cycle_o(skip),
    .effective_voltage_code_o(eff), .positive_current_limit_code_o(plim),
    .negative_current_limit_code_o(nlim), .monitor_channel_o(chan),
    .monitor_output_enable_o(oe_m), .monitor_scale_alt_o(alt),
    .soft_reset_o(srst));

  sw_pin_model u_pin (.drv_i(pin_o), .oe_n_i(oe_n), .ext_low_i(ext_low),
    .level_o(pin));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] sat(logic [25:0] c, logic [3:0] n);
    logic [31:0] v, hi, lo;
    v = {{6{c[25]}}, c};
    hi = {8'h00, n, 20'hf_ffff};
    lo = {8'hff, n, 20'h0_0000};
    if ($signed(v) > $signed(hi)) return hi;
    if ($signed(v) < $signed(lo)) return lo;
    return v;
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic wreg(logic [7:0] a, logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask

  task automatic rreg(logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(negedge clock_i) begin
    if (rd_q) chk(rdata, exp_q.pop_front());
    rd_q = rd;
  end

  // Watchdog
  initial begin
    #(20000 * 100);
    fail_count++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] dflt [8];
    logic [25:0] cv [3];
    logic [31:0] r;
    logic [3:0] ch;
    logic a;
    dflt = '{32'h0008_a214, 32'h0000_0010, 32'h0000_01ff, 32'h0000_0000,
             32'hff00_0000, 32'h0000_000f, 32'h0000_0000, 32'h0000_0000};
    repeat (16) @(posedge clock_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) rreg(8'(i * 4), dflt[i]);
    rreg(8'h20, 32'h0000_0000);
    $display("test defaults done");
    for (int n = 0; n < 16; n++) begin
      r = xs();
      cv = '{26'h1ff_ffff, 26'h200_0000, r[25:0]};
      wreg(8'h14, {28'h000_0000, n[3:0]});
      wreg(8'h18, {28'h000_0000, n[3:0]});
      for (int k = 0; k < 3; k++) begin
        wreg(8'h10, {6'h00, cv[k]});
        tick(2);
        chk(eff, sat(cv[k], n[3:0]));
      end
      rreg(8'h10, {{6{cv[2][25]}}, cv[2]});
    end
    $display("test clamp done");
    wreg(8'h0c, 32'h0000_01ce);
    wreg(8'h08, 32'h0000_0030);
    tick(2);
    chk({14'h0000, plim, nlim}, {14'h0000, 9'h1ce, 9'h030});
    wreg(8'h04, 32'h0000_0000);
    wreg(8'h00, 32'h0008_a217);
    tick(2);
    chk({28'h000_0000, hiz, sw_en, lin_en, pin}, 32'h7);
    @(posedge clock_i);
    {cl, pl, mt} <= 3'b111;
    tick(2);
    chk({31'h0, skip}, 32'h1);
    rreg(8'h04, 32'h0000_000f);
    @(posedge clock_i);
    {cl, pl, mt} <= 3'b000;
    ext_low <= 1'b1;
    tick(2);
    chk({30'h0, hiz, sw_en}, 32'h2);
    @(posedge clock_i);
    ext_low <= 1'b0;
    tick(2);
    chk({31'h0, sw_en}, 32'h1);
    $display("test enables done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clock_i);
      flt <= 6'(1 << i);
      @(posedge clock_i);
      flt <= 6'h00;
      tick(2);
      chk({29'h0, pin, sw_en, lin_en}, 32'h0);
      r = (32'h1 << (i + 5)) | ((i == 1 || i == 3) ? 32'h10 : 32'h0);
      rreg(8'h04, r);
      wreg(8'h04, 32'h0000_0000);
      wreg(8'h00, 32'h0008_a217);
      tick(2);
      chk({29'h0, pin, sw_en, lin_en}, 32'h7);
    end
    @(posedge clock_i);
    fault <= 1'b1;
    tick(2);
    chk({30'h0, pin, sw_en}, 32'h0);
    @(posedge clock_i);
    fault <= 1'b0;
    flt <= 6'h04;
    @(posedge clock_i);
    flt <= 6'h00;
    wreg(8'h14, 32'h0000_0003);
    wreg(8'h00, 32'h0018_a214);
    tick(2);
    rreg(8'h04, 32'h0000_0090);
    rreg(8'h14, 32'h0000_000f);
    rreg(8'h00, 32'h0008_a214);
    $display("test faults done");
    for (int s = 0; s < 32; s++) begin
      ch = (s[3:0] > 4'hb) ? 4'hc : s[3:0];
      a = s[4] && s[3:0] >= 4'h5 && s[3:0] <= 4'hb && s[3:0] != 4'h9;
      wreg(8'h1c, {26'h0, s[4], s[0] ^ s[4], s[3:0]});
      tick(2);
      r = {26'h0, a, s[0] ^ s[4], ch};
      chk({26'h0, alt, oe_m, chan}, r);
    end
    $display("test monitor done");
    tick(4);
    stop_test();
  end
endmodule
